// >>> shared/fcu_consts.vh
/*
  Constants of the flash controller front end: unlock keys, address map of the
  flash regions, register offsets, control and status bit positions.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef FCU_CONSTS_VH
`define FCU_CONSTS_VH
`define FCU_KEY1       32'h45670123
`define FCU_KEY2       32'hcdef89ab
`define FCU_MAIN_BASE  32'h08000000
`define FCU_MAIN_LAST  32'h0801ffff
`define FCU_PAGE_SHIFT 10
`define FCU_PAGES      128
`define FCU_BOOT_BASE  32'h1fffb000
`define FCU_BOOT_LAST  32'h1ffff7ff
`define FCU_OPT_BASE   32'h1ffff800
`define FCU_OPT_LAST   32'h1ffff80f
`define FCU_OPT_WORDS  4
`define FCU_SIG_BASE   32'h1ffff7e0
`define FCU_SIG_LAST   32'h1ffff7f3
`define FCU_RG_NONE    3'h0
`define FCU_RG_MAIN    3'h1
`define FCU_RG_BOOT    3'h2
`define FCU_RG_OPT     3'h3
`define FCU_RG_SIG     3'h4
`define FCU_OFF_KEY    8'h00
`define FCU_OFF_OBKEY  8'h04
`define FCU_OFF_CTL    8'h08
`define FCU_OFF_STAT   8'h0c
`define FCU_OFF_ADDR   8'h10
`define FCU_OFF_OB     4'h2
`define FCU_CTL_PG     0
`define FCU_CTL_PER    1
`define FCU_CTL_MER    2
`define FCU_CTL_OPTION_PROGRAM_CMD   4
`define FCU_CTL_OPTION_ERASE_CMD   5
`define FCU_CTL_START  6
`define FCU_CTL_LK     7
`define FCU_CTL_OPTION_WRITE_ENABLED  9
`define FCU_CTL_RESET  32'h00000080
`define FCU_CTL_WMASK  32'h00000037
`define FCU_ST_BUSY    0
`define FCU_ST_WPERR   4
`define FCU_ST_ENDF    5
`endif

// >>> core/fcu_key_seq.v
/*
  Two-key unlock sequence checker, one per key register.
  Assumes wr_en is a single-cycle write strobe from the register bus on clock.
*/
`timescale 1ns/1ps
`include "fcu_consts.vh"
module fcu_key_seq (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  input  wire        armed,
  output wire        done,
  output wire        fault
);
  reg first_q;

  wire k1_ok = armed & ~first_q & (wr_data == `FCU_KEY1);
  wire k2_ok = armed & first_q & (wr_data == `FCU_KEY2);

  assign done  = wr_en & k2_ok;
  assign fault = wr_en & ~k1_ok & ~k2_ok;

  // A fault restarts the sequence, so a stale first key is never reused.
  always @(posedge clock) begin
    if (!rst_n) begin
      first_q <= 1'b0;
    end else if (wr_en) begin
      first_q <= k1_ok;
    end
  end
endmodule

// >>> core/fcu_sig_rom.v
/*
  Read-only signature words: size word and the three serial identifier words.
  Two read ports, one for each processor bus; purely combinational.
*/
`timescale 1ns/1ps
module fcu_sig_rom #(
  parameter [15:0] SRAM_KB  = 16'h0020,
  parameter [15:0] FLASH_KB = 16'h0080,
  parameter [95:0] SERIAL   = 96'h0123456789abcdef01234567
) (
  input  wire [2:0]  sel_a,
  input  wire [2:0]  sel_b,
  output wire [31:0] data_a,
  output wire [31:0] data_b
);
  function [31:0] word;
    input [2:0] s;
    begin
      case (s)
        3'h0:    word = {SRAM_KB, FLASH_KB};
        3'h2:    word = SERIAL[31:0];
        3'h3:    word = SERIAL[63:32];
        3'h4:    word = SERIAL[95:64];
        default: word = 32'h0;
      endcase
    end
  endfunction

  assign data_a = word(sel_a);
  assign data_b = word(sel_b);
endmodule

// >>> core/fcu_flash_ctrl.v
/*
  Flash controller front end: address map, zero-wait reads on the instruction bus
  and, once the option byte load is over, the data bus, two-key unlock of the control register and option bits,
  option byte load after reset and launch of program and erase operations.
  Assumes an external flash array with combinational read ports and a
  one-cycle done pulse per operation, and an APB master on the same clock.
*/
`timescale 1ns/1ps
`include "fcu_consts.vh"
module fcu_flash_ctrl #(
  parameter [15:0] SRAM_KB  = 16'h0020,
  parameter [15:0] FLASH_KB = 16'h0080,
  parameter [95:0] SERIAL   = 96'h0123456789abcdef01234567
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        instruction_bus_valid,
  input  wire [31:0] instruction_bus_addr,
  output wire        instruction_bus_ready,
  output wire        instruction_bus_rvalid,
  output wire [31:0] instruction_bus_rdata,
  output wire        instruction_bus_err,
  input  wire        data_bus_valid,
  input  wire        data_bus_we,
  input  wire        data_bus_half,
  input  wire [31:0] data_bus_addr,
  input  wire [31:0] data_bus_wdata,
  output wire        data_bus_ready,
  output wire        data_bus_rvalid,
  output wire [31:0] data_bus_rdata,
  output wire        data_bus_err,
  output wire [31:0] flash_iaddr,
  input  wire [31:0] flash_irdata,
  output wire [31:0] flash_daddr,
  input  wire [31:0] flash_drdata,
  output wire        flash_prog,
  output wire        flash_page_erase,
  output wire        flash_mass_erase,
  output wire        flash_opt_erase,
  output wire        flash_opt_prog,
  output wire [31:0] flash_op_addr,
  output wire [6:0]  flash_page,
  output wire [31:0] flash_op_data,
  output wire        flash_op_half,
  input  wire        flash_done
);
  localparam [1:0] L_LOAD = 2'b01;
  localparam [1:0] L_RUN  = 2'b10;
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_BUSY = 2'b10;

  reg [31:0] ctl_q;
  reg [31:0] ctl_d;
  reg [31:0] addr_q;
  reg        wperr_q;
  reg        endf_q;
  reg [1:0]  ld_state_q;
  reg [1:0]  ld_idx_q;
  reg [1:0]  op_state_q;
  reg [1:0]  op_state_d;
  reg [31:0] ob_q [0:`FCU_OPT_WORDS-1];
  reg [31:0] prdata_q;
  reg        instruction_bus_rvalid_q;
  reg [31:0] instruction_bus_rdata_q;
  reg        instruction_bus_err_q;
  reg        data_bus_rvalid_q;
  reg [31:0] data_bus_rdata_q;
  reg        data_bus_err_q;
  reg        prog_q;
  reg        perase_q;
  reg        merase_q;
  reg        oerase_q;
  reg        oprog_q;
  reg [31:0] op_addr_q;
  reg [31:0] op_data_q;
  reg        op_half_q;
  reg        launch_prog;
  reg        launch_perase;
  reg        launch_merase;
  reg        launch_oerase;
  reg        launch_oprog;
  reg        wp_hit;

  function [2:0] fcu_region;
    input [31:0] a;
    begin
      if (a >= `FCU_SIG_BASE && a <= `FCU_SIG_LAST)
        fcu_region = `FCU_RG_SIG;
      else if (a >= `FCU_MAIN_BASE && a <= `FCU_MAIN_LAST)
        fcu_region = `FCU_RG_MAIN;
      else if (a >= `FCU_BOOT_BASE && a <= `FCU_BOOT_LAST)
        fcu_region = `FCU_RG_BOOT;
      else if (a >= `FCU_OPT_BASE && a <= `FCU_OPT_LAST)
        fcu_region = `FCU_RG_OPT;
      else
        fcu_region = `FCU_RG_NONE;
    end
  endfunction

  function fcu_mapped;
    input [7:0] a;
    begin
      fcu_mapped = (a == `FCU_OFF_KEY) || (a == `FCU_OFF_OBKEY) ||
                   (a == `FCU_OFF_CTL) || (a == `FCU_OFF_STAT) ||
                   (a == `FCU_OFF_ADDR) || (a[7:4] == `FCU_OFF_OB);
    end
  endfunction

  // Register bus decode; the slave never stalls.
  wire acc      = psel & penable;
  wire apb_wr   = acc & pwrite;
  wire key_wr   = apb_wr & (paddr == `FCU_OFF_KEY);
  wire obkey_wr = apb_wr & (paddr == `FCU_OFF_OBKEY);
  wire ctl_wr   = apb_wr & (paddr == `FCU_OFF_CTL);
  wire stat_wr  = apb_wr & (paddr == `FCU_OFF_STAT);
  wire addr_wr  = apb_wr & (paddr == `FCU_OFF_ADDR);
  wire locked   = ctl_q[`FCU_CTL_LK];
  wire option_write_enabled    = ctl_q[`FCU_CTL_OPTION_WRITE_ENABLED];
  wire running  = (ld_state_q == L_RUN);
  wire idle     = (op_state_q == S_IDLE);
  wire key_done;
  wire key_fault;
  wire obkey_done;
  wire obkey_fault;

  fcu_key_seq u_key (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (key_wr),
    .wr_data (pwdata),
    .armed   (locked),
    .done    (key_done),
    .fault   (key_fault)
  );

  // The option keys are only heard once the control register is open.
  fcu_key_seq u_obkey (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (obkey_wr),
    .wr_data (pwdata),
    .armed   (~locked),
    .done    (obkey_done),
    .fault   (obkey_fault)
  );

  assign pready  = 1'b1;
  assign pslverr = acc & (~fcu_mapped(paddr) | key_fault | obkey_fault);
  assign prdata  = prdata_q;

  // Control register next value.
  always @* begin
    ctl_d = ctl_q;
    if (ctl_wr && !locked) begin
      ctl_d = (ctl_q & ~`FCU_CTL_WMASK) | (pwdata & `FCU_CTL_WMASK);
      if (!option_write_enabled) begin
        ctl_d[`FCU_CTL_OPTION_PROGRAM_CMD] = ctl_q[`FCU_CTL_OPTION_PROGRAM_CMD];
        ctl_d[`FCU_CTL_OPTION_ERASE_CMD] = ctl_q[`FCU_CTL_OPTION_ERASE_CMD];
      end
      if (!pwdata[`FCU_CTL_OPTION_WRITE_ENABLED])
        ctl_d[`FCU_CTL_OPTION_WRITE_ENABLED] = 1'b0;
      if (pwdata[`FCU_CTL_LK])
        ctl_d[`FCU_CTL_LK] = 1'b1;
    end
    if (key_done)
      ctl_d[`FCU_CTL_LK] = 1'b0;
    if (key_fault)
      ctl_d[`FCU_CTL_LK] = 1'b1;
    if (obkey_done)
      ctl_d[`FCU_CTL_OPTION_WRITE_ENABLED] = 1'b1;
    if (!ctl_d[`FCU_CTL_OPTION_WRITE_ENABLED]) begin
      ctl_d[`FCU_CTL_OPTION_PROGRAM_CMD] = 1'b0;
      ctl_d[`FCU_CTL_OPTION_ERASE_CMD] = 1'b0;
    end
    ctl_d[`FCU_CTL_START] = 1'b0;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      ctl_q  <= `FCU_CTL_RESET;
      addr_q <= 32'h0;
    end else begin
      ctl_q <= ctl_d;
      if (addr_wr)
        addr_q <= pwdata;
    end
  end

  // Read data is captured in the setup phase so the access phase sees a flop.
  always @(posedge clock) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0;
      if (paddr == `FCU_OFF_CTL)
        prdata_q <= ctl_q;
      else if (paddr == `FCU_OFF_STAT)
        prdata_q <= {26'h0, endf_q, wperr_q, 3'h0, ~idle};
      else if (paddr == `FCU_OFF_ADDR)
        prdata_q <= addr_q;
      else if (paddr[7:4] == `FCU_OFF_OB)
        prdata_q <= ob_q[paddr[3:2]];
    end
  end

  // Option byte load: one word per cycle straight after reset release.
  always @(posedge clock) begin
    if (!rst_n) begin
      ld_state_q <= L_LOAD;
      ld_idx_q   <= 2'h0;
    end else begin
      case (ld_state_q)
        L_LOAD: begin
          ob_q[ld_idx_q] <= flash_drdata;
          ld_idx_q       <= ld_idx_q + 2'h1;
          if (ld_idx_q == 2'h3)
            ld_state_q <= L_RUN;
        end
        L_RUN: ld_state_q <= L_RUN;
        default: ld_state_q <= L_LOAD;
      endcase
    end
  end

  // Processor buses and the signature words.
  wire [2:0]  ireg = fcu_region(instruction_bus_addr);
  wire [2:0]  dreg = fcu_region(data_bus_addr);
  wire [31:0] isig;
  wire [31:0] dsig;

  fcu_sig_rom #(
    .SRAM_KB  (SRAM_KB),
    .FLASH_KB (FLASH_KB),
    .SERIAL   (SERIAL)
  ) u_sig (
    .sel_a  (instruction_bus_addr[4:2]),
    .sel_b  (data_bus_addr[4:2]),
    .data_a (isig),
    .data_b (dsig)
  );

  assign flash_iaddr = instruction_bus_addr;
  assign flash_daddr = running ? data_bus_addr : (`FCU_OPT_BASE | {28'h0, ld_idx_q, 2'h0});
  assign instruction_bus_ready  = 1'b1;
  // The data bus waits only while the option bytes are being loaded.
  assign data_bus_ready  = running;

  wire d_wr   = data_bus_valid & running & data_bus_we;
  wire d_rd   = data_bus_valid & running & ~data_bus_we;
  wire prog_ok  = d_wr & idle & ctl_q[`FCU_CTL_PG] & (dreg == `FCU_RG_MAIN);
  wire oprog_ok = d_wr & idle & option_write_enabled & ctl_q[`FCU_CTL_OPTION_PROGRAM_CMD] & (dreg == `FCU_RG_OPT);

  always @(posedge clock) begin
    if (!rst_n) begin
      instruction_bus_rvalid_q <= 1'b0;
      instruction_bus_rdata_q  <= 32'h0;
      instruction_bus_err_q    <= 1'b0;
      data_bus_rvalid_q <= 1'b0;
      data_bus_rdata_q  <= 32'h0;
      data_bus_err_q    <= 1'b0;
    end else begin
      instruction_bus_rvalid_q <= instruction_bus_valid;
      instruction_bus_err_q    <= instruction_bus_valid & (ireg == `FCU_RG_NONE);
      if (instruction_bus_valid)
        instruction_bus_rdata_q <= (ireg == `FCU_RG_SIG) ? isig :
                        (ireg == `FCU_RG_NONE) ? 32'h0 : flash_irdata;
      data_bus_rvalid_q <= data_bus_valid & running;
      // Writes that start no operation, signature writes among them, are refused.
      data_bus_err_q    <= (d_rd & (dreg == `FCU_RG_NONE)) | (d_wr & ~prog_ok & ~oprog_ok);
      if (d_rd)
        data_bus_rdata_q <= (dreg == `FCU_RG_SIG) ? dsig :
                        (dreg == `FCU_RG_NONE) ? 32'h0 : flash_drdata;
    end
  end

  assign instruction_bus_rvalid = instruction_bus_rvalid_q;
  assign instruction_bus_rdata  = instruction_bus_rdata_q;
  assign instruction_bus_err    = instruction_bus_err_q;
  assign data_bus_rvalid = data_bus_rvalid_q;
  assign data_bus_rdata  = data_bus_rdata_q;
  assign data_bus_err    = data_bus_err_q;

  // Operation launch. A start with a page erase aimed outside the main flash
  // is dropped and flagged; the boot loader block can never be altered.
  wire start_req = ctl_wr & ~locked & pwdata[`FCU_CTL_START] & idle;
  wire [2:0] areg = fcu_region(addr_q);

  always @* begin
    launch_prog   = prog_ok;
    launch_oprog  = oprog_ok;
    launch_perase = 1'b0;
    launch_merase = 1'b0;
    launch_oerase = 1'b0;
    wp_hit        = d_wr & (ctl_q[`FCU_CTL_PG] | ctl_q[`FCU_CTL_OPTION_PROGRAM_CMD]) &
                    ((dreg == `FCU_RG_BOOT) | (dreg == `FCU_RG_SIG));
    if (start_req) begin
      if (pwdata[`FCU_CTL_MER]) begin
        launch_merase = 1'b1;
      end else if (pwdata[`FCU_CTL_PER]) begin
        if (areg == `FCU_RG_MAIN)
          launch_perase = 1'b1;
        else
          wp_hit = 1'b1;
      end else if (pwdata[`FCU_CTL_OPTION_ERASE_CMD] && option_write_enabled) begin
        launch_oerase = 1'b1;
      end
    end
    op_state_d = op_state_q;
    case (op_state_q)
      S_IDLE: if (launch_prog | launch_oprog | launch_perase | launch_merase | launch_oerase)
                op_state_d = S_BUSY;
      S_BUSY: if (flash_done)
                op_state_d = S_IDLE;
      default: op_state_d = S_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      op_state_q <= S_IDLE;
      prog_q     <= 1'b0;
      perase_q   <= 1'b0;
      merase_q   <= 1'b0;
      oerase_q   <= 1'b0;
      oprog_q    <= 1'b0;
      op_addr_q  <= 32'h0;
      op_data_q  <= 32'h0;
      op_half_q  <= 1'b0;
      wperr_q    <= 1'b0;
      endf_q     <= 1'b0;
    end else begin
      op_state_q <= op_state_d;
      prog_q     <= launch_prog;
      perase_q   <= launch_perase;
      merase_q   <= launch_merase;
      oerase_q   <= launch_oerase;
      oprog_q    <= launch_oprog;
      if (launch_prog | launch_oprog) begin
        op_addr_q <= data_bus_addr;
        op_data_q <= data_bus_wdata;
        op_half_q <= data_bus_half;
      end else if (launch_perase) begin
        op_addr_q <= addr_q;
      end
      // A new event wins over a clear in the same cycle.
      wperr_q <= wp_hit | (wperr_q & ~(stat_wr & pwdata[`FCU_ST_WPERR]));
      endf_q  <= (~idle & flash_done) | (endf_q & ~(stat_wr & pwdata[`FCU_ST_ENDF]));
    end
  end

  assign flash_prog       = prog_q;
  assign flash_page_erase = perase_q;
  assign flash_mass_erase = merase_q;
  assign flash_opt_erase  = oerase_q;
  assign flash_opt_prog   = oprog_q;
  assign flash_op_addr    = op_addr_q;
  assign flash_page       = op_addr_q[`FCU_PAGE_SHIFT+6:`FCU_PAGE_SHIFT];
  assign flash_op_data    = op_data_q;
  assign flash_op_half    = op_half_q;
endmodule

// >>> tb/fcu_flash_ctrl_chk.sv
/* Port checker of the flash controller front end.
   Assumes one clock and a synchronous active-low reset; bound to fcu_flash_ctrl. */
`timescale 1ns/1ps
`include "fcu_consts.vh"
module fcu_flash_ctrl_chk #(
  parameter [15:0] SRAM_KB  = 16'h0020,
  parameter [15:0] FLASH_KB = 16'h0080,
  parameter [95:0] SERIAL   = 96'h0
) (
  input wire        clock,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pslverr,
  input wire        instruction_bus_valid,
  input wire [31:0] instruction_bus_addr,
  input wire        instruction_bus_rvalid,
  input wire [31:0] instruction_bus_rdata,
  input wire        instruction_bus_err,
  input wire [31:0] flash_irdata,
  input wire        data_bus_valid,
  input wire        data_bus_we,
  input wire        data_bus_ready,
  input wire [31:0] data_bus_addr,
  input wire        data_bus_err,
  input wire        flash_prog,
  input wire        flash_opt_prog,
  input wire [31:0] flash_op_addr,
  input wire [6:0]  flash_page
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  function automatic bit inr(input [31:0] a, input [31:0] lo, input [31:0] hi);
    return a >= lo && a <= hi;
  endfunction
  wire wr_key = psel && penable && pwrite && paddr == `FCU_OFF_KEY;
  // Key one must have been accepted, so the second key meets an armed sequence.
  sequence s_key1; wr_key && pwdata == `FCU_KEY1 && !pslverr; endsequence
  sequence s_key2; wr_key && pwdata == `FCU_KEY2; endsequence
  chk_unlock_ok: assert property (s_key1 ##3 s_key2 |-> !pslverr)
    else $error("second unlock key refused");
  chk_bad_key: assert property (wr_key && pwdata != `FCU_KEY1 && pwdata != `FCU_KEY2 |-> pslverr)
    else $error("wrong key accepted");
  chk_fetch_wait: assert property (instruction_bus_valid |=> instruction_bus_rvalid)
    else $error("fetch answer late");
  chk_fetch_data: assert property (instruction_bus_valid && inr(instruction_bus_addr, `FCU_MAIN_BASE, `FCU_MAIN_LAST)
    |=> instruction_bus_rdata == $past(flash_irdata) && !instruction_bus_err) else $error("fetch data wrong");
  chk_size_word: assert property (instruction_bus_valid && instruction_bus_addr == `FCU_SIG_BASE
    |=> instruction_bus_rdata == {SRAM_KB, FLASH_KB}) else $error("size word wrong");
  chk_serial_low: assert property (instruction_bus_valid && instruction_bus_addr == `FCU_SIG_BASE + 32'h8
    |=> instruction_bus_rdata == SERIAL[31:0]) else $error("serial low word wrong");
  chk_boot_refused: assert property (data_bus_valid && data_bus_ready && data_bus_we
    && inr(data_bus_addr, `FCU_BOOT_BASE, `FCU_BOOT_LAST) |=> data_bus_err && !flash_prog && !flash_opt_prog)
    else $error("boot block write not refused");
  chk_page_index: assert property (flash_prog |-> flash_page == flash_op_addr[16:10]
    && inr(flash_op_addr, `FCU_MAIN_BASE, `FCU_MAIN_LAST)) else $error("page index wrong");
  chk_opt_range: assert property (flash_opt_prog
    |-> inr(flash_op_addr, `FCU_OPT_BASE, `FCU_OPT_LAST)) else $error("option write outside block");
endmodule
bind fcu_flash_ctrl fcu_flash_ctrl_chk #(.SRAM_KB(SRAM_KB), .FLASH_KB(FLASH_KB), .SERIAL(SERIAL)) u_chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .instruction_bus_valid(instruction_bus_valid), .instruction_bus_addr(instruction_bus_addr),
  .instruction_bus_rvalid(instruction_bus_rvalid), .instruction_bus_rdata(instruction_bus_rdata), .instruction_bus_err(instruction_bus_err), .flash_irdata(flash_irdata),
  .data_bus_valid(data_bus_valid), .data_bus_we(data_bus_we), .data_bus_ready(data_bus_ready), .data_bus_addr(data_bus_addr),
  .data_bus_err(data_bus_err), .flash_prog(flash_prog), .flash_opt_prog(flash_opt_prog),
  .flash_op_addr(flash_op_addr), .flash_page(flash_page));

// >>> tb/fcu_flash_model.sv
/* Behavioural flash array: each word reads as the inverse of its address,
   every operation ends with a done pulse. Assumes one-cycle operation pulses. */
`timescale 1ns/1ps
module fcu_flash_model #(
  parameter [3:0] LAT = 4'h3
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [31:0] iaddr,
  input  wire [31:0] daddr,
  input  wire        op,
  output wire [31:0] irdata,
  output wire [31:0] drdata,
  output reg         done_q
);
  reg [3:0] cnt_q;
  // Contents follow the address, so a wrong word or a stale address shows up.
  assign irdata = ~iaddr;
  assign drdata = ~daddr;
  always @(posedge clock) begin
    done_q <= 1'h0;
    if (!rst_n)
      cnt_q <= 4'h0;
    else if (op)
      cnt_q <= LAT;
    else if (cnt_q != 4'h0) begin
      cnt_q  <= cnt_q - 4'h1;
      done_q <= cnt_q == 4'h1;
    end
  end
endmodule

// >>> tb/tb_fcu_flash_ctrl.sv
/* Self-checking bench of the flash controller front end over APB and both buses.
   Assumes the flash model beside it and the bound port checker. */
`timescale 1ns/1ps
`include "fcu_consts.vh"
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin n_errors++; $display("mismatch at %0t: got %h exp %h", $time, g, x); end end
module tb_fcu_flash_ctrl;
  localparam [95:0] SER = 96'h13579bdf02468ace55aa33cc;
  reg         clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, instruction_bus_addr = 32'h0, data_bus_addr = 32'h0, data_bus_wdata = 32'h0, r;
  reg         instruction_bus_valid = 1'h0, data_bus_valid = 1'h0, data_bus_we = 1'h0, data_bus_half = 1'h0, e, l_half;
  reg  [6:0]  l_page;
  wire [31:0] prdata, instruction_bus_rdata, data_bus_rdata, f_iaddr, f_irdata, f_daddr, f_drdata, op_addr;
  wire        pready, pslverr, instruction_bus_rvalid, instruction_bus_err, data_bus_ready, data_bus_rvalid, data_bus_err, op_half, f_done;
  wire        f_prog, f_per, f_mer, f_obe, f_obp;
  wire [6:0]  f_page;
  wire        f_any = f_prog | f_per | f_mer | f_obe | f_obp;
  integer     n_errors = 0, check_count = 0, n_ops = 0, k;
  always #50 clock = ~clock;
  always @(posedge clock) if (f_any === 1'h1) begin
    n_ops  <= n_ops + 1;
    l_page <= f_page;
    l_half <= op_half;
  end
  fcu_flash_ctrl #(.SRAM_KB(16'h0010), .FLASH_KB(16'h0080), .SERIAL(SER)) u_fcu_flash_ctrl (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instruction_bus_valid(instruction_bus_valid),
    .instruction_bus_addr(instruction_bus_addr), .instruction_bus_ready(), .instruction_bus_rvalid(instruction_bus_rvalid), .instruction_bus_rdata(instruction_bus_rdata),
    .instruction_bus_err(instruction_bus_err), .data_bus_valid(data_bus_valid), .data_bus_we(data_bus_we), .data_bus_half(data_bus_half),
    .data_bus_addr(data_bus_addr), .data_bus_wdata(data_bus_wdata), .data_bus_ready(data_bus_ready), .data_bus_rvalid(data_bus_rvalid),
    .data_bus_rdata(data_bus_rdata), .data_bus_err(data_bus_err), .flash_iaddr(f_iaddr), .flash_irdata(f_irdata),
    .flash_daddr(f_daddr), .flash_drdata(f_drdata), .flash_prog(f_prog), .flash_page_erase(f_per),
    .flash_mass_erase(f_mer), .flash_opt_erase(f_obe), .flash_opt_prog(f_obp), .flash_op_addr(op_addr),
    .flash_page(f_page), .flash_op_data(), .flash_op_half(op_half), .flash_done(f_done));
  fcu_flash_model u_fcu_flash_model (.clock(clock), .rst_n(rst_n), .iaddr(f_iaddr), .daddr(f_daddr),
    .op(f_any), .irdata(f_irdata), .drdata(f_drdata), .done_q(f_done));
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock) penable <= 1'h1;
    i = 0;
    // The answer is taken at the very edge that samples pready high, before any flop updates.
    do begin @(posedge clock); i++; end while (pready !== 1'h1 && i < 16);
    r = prdata;
    e = pslverr;
    if (i >= 16) begin n_errors++; end_sim; end
    psel <= 1'h0; penable <= 1'h0; pwdata <= ~d;
    @(posedge clock);
  endtask
  task rd(input [7:0] a, input [31:0] x); apb(1'h0, a, 32'h0); `CHK(r, x) endtask
  task wr(input [7:0] a, input [31:0] d, input x); apb(1'h1, a, d); `CHK(e, x) endtask
  task idle;
    integer i;
    i = 0;
    do begin apb(1'h0, `FCU_OFF_STAT, 32'h0); i++; end while (r[0] !== 1'h0 && i < 20);
    if (i >= 20) begin n_errors++; end_sim; end
  endtask
  task bus(input d, input w, input h, input [31:0] a, input [31:0] wd, input [31:0] xd, input xe);
    integer i;
    i = 0;
    while (d && data_bus_ready !== 1'h1 && i < 16) begin @(negedge clock); i++; end
    if (i >= 16) begin n_errors++; end_sim; end
    @(posedge clock);
    if (d) begin data_bus_valid <= 1'h1; data_bus_we <= w; data_bus_half <= h; data_bus_addr <= a; data_bus_wdata <= wd; end
    else begin instruction_bus_valid <= 1'h1; instruction_bus_addr <= a; end
    @(posedge clock);
    data_bus_valid <= 1'h0; instruction_bus_valid <= 1'h0; data_bus_addr <= ~a; instruction_bus_addr <= ~a; data_bus_wdata <= ~wd;
    @(negedge clock);
    `CHK(d ? {data_bus_rvalid, data_bus_err} : {instruction_bus_rvalid, instruction_bus_err}, {1'h1, xe})
    if (!w) `CHK(d ? data_bus_rdata : instruction_bus_rdata, xd)
    @(posedge clock);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    rd(`FCU_OFF_CTL, `FCU_CTL_RESET);
    for (k = 0; k < 4; k++) rd(8'(8'h20 + 4 * k), ~(`FCU_OPT_BASE + 32'h4 * k));
    $display("test reset done");
    wr(`FCU_OFF_CTL, 32'h7, 1'h0);
    rd(`FCU_OFF_CTL, `FCU_CTL_RESET);
    wr(`FCU_OFF_KEY, 32'h12345678, 1'h1);
    wr(`FCU_OFF_KEY, `FCU_KEY2, 1'h1);
    rd(`FCU_OFF_CTL, `FCU_CTL_RESET);
    wr(`FCU_OFF_KEY, `FCU_KEY1, 1'h0);
    wr(`FCU_OFF_KEY, `FCU_KEY2, 1'h0);
    rd(`FCU_OFF_CTL, 32'h0);
    wr(`FCU_OFF_CTL, 32'h31, 1'h0);
    rd(`FCU_OFF_CTL, 32'h1);
    wr(`FCU_OFF_OBKEY, `FCU_KEY1, 1'h0);
    wr(`FCU_OFF_OBKEY, `FCU_KEY2, 1'h0);
    rd(`FCU_OFF_CTL, 32'h201);
    wr(`FCU_OFF_CTL, 32'h211, 1'h0);
    rd(`FCU_OFF_CTL, 32'h211);
    bus(1'h1, 1'h1, 1'h0, `FCU_OPT_BASE, 32'h00ff00ff, 32'h0, 1'h0);
    idle;
    `CHK(n_ops, 1)
    wr(`FCU_OFF_CTL, 32'h011, 1'h0);
    rd(`FCU_OFF_CTL, 32'h001);
    bus(1'h1, 1'h1, 1'h0, `FCU_OPT_BASE, 32'h00ff00ff, 32'h0, 1'h1);
    $display("test unlock done");
    bus(1'h1, 1'h1, 1'h0, 32'h08000404, 32'h12345678, 32'h0, 1'h0);
    idle;
    `CHK(l_page, 7'h01)
    bus(1'h1, 1'h1, 1'h1, 32'h0801fc00, 32'h0000abcd, 32'h0, 1'h0);
    idle;
    `CHK({l_half, l_page}, 8'hff)
    bus(1'h1, 1'h1, 1'h0, `FCU_BOOT_BASE, 32'h0, 32'h0, 1'h1);
    bus(1'h1, 1'h1, 1'h0, `FCU_SIG_BASE, 32'h0, 32'h0, 1'h1);
    `CHK(n_ops, 3)
    wr(`FCU_OFF_CTL, 32'h2, 1'h0);
    wr(`FCU_OFF_ADDR, 32'h08000c00, 1'h0);
    wr(`FCU_OFF_CTL, 32'h42, 1'h0);
    idle;
    `CHK({n_ops == 4, l_page}, 8'h83)
    wr(`FCU_OFF_CTL, 32'h44, 1'h0);
    idle;
    `CHK(n_ops, 5)
    $display("test program done");
    bus(1'h0, 1'h0, 1'h0, 32'h08000404, 32'h0, ~32'h08000404, 1'h0);
    bus(1'h1, 1'h0, 1'h0, 32'h0801fffc, 32'h0, ~32'h0801fffc, 1'h0);
    bus(1'h0, 1'h0, 1'h0, `FCU_SIG_BASE, 32'h0, 32'h00100080, 1'h0);
    bus(1'h1, 1'h0, 1'h0, `FCU_SIG_BASE, 32'h0, 32'h00100080, 1'h0);
    for (k = 0; k < 3; k++) bus(1'h0, 1'h0, 1'h0, `FCU_SIG_BASE + 32'h8 + 32'h4 * k, 32'h0, SER[32 * k +: 32], 1'h0);
    bus(1'h0, 1'h0, 1'h0, 32'h0, 32'h0, 32'h0, 1'h1);
    $display("test read done");
    wr(`FCU_OFF_CTL, 32'h0, 1'h0);
    wr(`FCU_OFF_CTL, 32'h80, 1'h0);
    wr(`FCU_OFF_CTL, 32'h1, 1'h0);
    rd(`FCU_OFF_CTL, 32'h80);
    $display("test relock done");
    end_sim;
  end
endmodule
